// File: psc_strap_config.sv
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module psc_strap_config #(
  parameter int unsigned NPORTS = psc_pkg::NUM_PORTS
) (
  input  wire logic                       i_core_clk,
  input  wire logic                       i_rst,
  // APB slave
  input  wire logic                       i_psel,
  input  wire logic                       i_penable,
  input  wire logic                       i_pwrite,
  input  wire logic [psc_pkg::ADDR_W-1:0] i_paddr,
  input  wire logic [psc_pkg::DATA_W-1:0] i_pwdata,
  output logic      [psc_pkg::DATA_W-1:0] o_prdata,
  output logic                            o_pready,
  output logic                            o_pslverr,
  // Straps from pins
  input  wire logic [NPORTS-1:0]          i_aneg_strap,
  input  wire logic [NPORTS-1:0]          i_duplex_strap,
  input  wire logic [NPORTS-1:0]          i_carrier_sense_select_strap,
  input  wire logic [NPORTS-1:0]          i_serial_mode_strap,
  input  wire logic [NPORTS-1:0]          i_carrier_integrity_strap,
  input  wire logic [NPORTS-1:0]          i_codec_bypass_strap,
  input  wire logic [NPORTS-1:0]          i_scrambler_bypass_strap,
  input  wire logic [NPORTS-1:0]          i_speed_strap,
  input  wire logic [NPORTS-1:0]          i_fiber_mode_strap,
  input  wire logic                       i_broadcast_mgmt_strap,
  input  wire logic [2:0]                 i_mgmt_address_upper_strap,
  // Core-side inputs
  input  wire logic [NPORTS-1:0]          i_aneg_full_duplex,
  input  wire logic [NPORTS-1:0]          i_aneg_speed_100,
  input  wire logic [NPORTS-1:0]          i_rx_active,
  input  wire logic [NPORTS-1:0]          i_tx_active,
  input  wire logic [4:0]                 i_frame_addr,
  input  wire logic                       i_frame_valid,
  // Merged settings
  output logic      [NPORTS-1:0]          o_aneg_enable,
  output logic      [NPORTS-1:0]          o_aneg_restart,
  output logic      [NPORTS-1:0]          o_full_duplex,
  output logic      [NPORTS-1:0]          o_speed_100,
  output logic      [NPORTS-1:0]          o_crs_rx_only,
  output logic      [NPORTS-1:0]          o_serial_mode,
  output logic      [NPORTS-1:0]          o_cim_enable,
  output logic      [NPORTS-1:0]          o_codec_bypass,
  output logic      [NPORTS-1:0]          o_scrambler_bypass,
  output logic      [NPORTS-1:0]          o_fiber_mode,
  output logic      [NPORTS-1:0]          o_carrier_sense_out,
  output logic      [5*NPORTS-1:0]        o_mgmt_addr,
  output logic      [NPORTS-1:0]          o_addr_hit
);

  localparam int unsigned SYNC_W = 9 * NPORTS + 4;

  // ---------------------------------------------------------------
  // Strap synchroniser
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync1_d;

  logic [SYNC_W-1:0] sync2_q;
  logic [SYNC_W-1:0] sync2_d;

  always_comb begin
    sync1_d = {i_aneg_strap,
               i_duplex_strap,
               i_carrier_sense_select_strap,
               i_serial_mode_strap,
               i_carrier_integrity_strap,
               i_codec_bypass_strap,
               i_scrambler_bypass_strap,
               i_speed_strap,
               i_fiber_mode_strap,
               i_broadcast_mgmt_strap,
               i_mgmt_address_upper_strap};
    sync2_d = sync1_q;
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  logic [NPORTS-1:0] s_aneg;
  logic [NPORTS-1:0] s_dup;
  logic [NPORTS-1:0] s_crs;
  logic [NPORTS-1:0] s_ser;
  logic [NPORTS-1:0] s_cim;
  logic [NPORTS-1:0] s_cod;
  logic [NPORTS-1:0] s_scr;
  logic [NPORTS-1:0] s_spd;
  logic [NPORTS-1:0] s_fib;

  logic              s_bcast;
  logic [2:0]        s_upper;

  assign {s_aneg,
          s_dup,
          s_crs,
          s_ser,
          s_cim,
          s_cod,
          s_scr,
          s_spd,
          s_fib,
          s_bcast,
          s_upper} = sync2_q;

  // ---------------------------------------------------------------
  // APB register file
  // ---------------------------------------------------------------
  logic [psc_pkg::CTRL_W-1:0] ctrl_q [NPORTS];
  logic [psc_pkg::CTRL_W-1:0] ctrl_d [NPORTS];

  logic [psc_pkg::DATA_W-1:0] prdata_q;
  logic [psc_pkg::DATA_W-1:0] prdata_d;

  logic                       pready_q;
  logic                       pready_d;

  logic                       pslverr_q;
  logic                       pslverr_d;

  logic [psc_pkg::DATA_W-1:0] stat_word [NPORTS];

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  logic                       setup;
  logic                       wr_done;
  logic [NPORTS-1:0]          wr_port;

  logic                       hit_ctrl;
  logic                       hit_stat;
  logic                       hit_glob;

  logic [psc_pkg::ADDR_W-1:0] rel_ctrl;
  logic [psc_pkg::ADDR_W-1:0] rel_stat;

  logic [1:0]                 sel_idx_c;
  logic [1:0]                 sel_idx_s;

  always_comb begin
    setup     = i_psel & ~i_penable;
    wr_done   = i_psel & i_penable & pready_q
                & i_pwrite & ~pslverr_q;
    rel_ctrl  = i_paddr - psc_pkg::OFS_CTRL_BASE;
    rel_stat  = i_paddr - psc_pkg::OFS_STAT_BASE;
    sel_idx_c = rel_ctrl[3:2];
    sel_idx_s = rel_stat[3:2];
    hit_ctrl  = (i_paddr >= psc_pkg::OFS_CTRL_BASE) && (i_paddr[1:0] == 2'h0)
                && (i_paddr < psc_pkg::OFS_STAT_BASE);
    hit_stat  = (i_paddr >= psc_pkg::OFS_STAT_BASE) && (i_paddr[1:0] == 2'h0)
                && (i_paddr < psc_pkg::OFS_GLOBAL);
    hit_glob  = (i_paddr == psc_pkg::OFS_GLOBAL);
    for (int p = 0; p < NPORTS; p++) begin
      wr_port[p] = wr_done & hit_ctrl & (sel_idx_c == 2'(p));
    end
  end

  // ---------------------------------------------------------------
  // APB answer
  // ---------------------------------------------------------------
  always_comb begin
    pready_d  = setup;
    pslverr_d = setup & ~(hit_ctrl | hit_stat | hit_glob);
    prdata_d  = prdata_q;
    if (setup) begin
      prdata_d = 32'h0000_0000;
      if (!i_pwrite) begin
        if (hit_ctrl) begin
          prdata_d[psc_pkg::CTRL_W-1:0] = ctrl_q[sel_idx_c];
        end else if (hit_stat) begin
          prdata_d = stat_word[sel_idx_s];
        end else if (hit_glob) begin
          prdata_d[psc_pkg::BIT_BCAST] = s_bcast;
          prdata_d[psc_pkg::BIT_UPPER +: 3] = s_upper;
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign o_prdata  = prdata_q;
  assign o_pready  = pready_q;
  assign o_pslverr = pslverr_q;

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_comb begin
    for (int p = 0; p < NPORTS; p++) begin
      ctrl_d[p] = ctrl_q[p];
      if (wr_port[p]) begin
        ctrl_d[p] = i_pwdata[psc_pkg::CTRL_W-1:0] & psc_pkg::CTRL_WMASK;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int p = 0; p < NPORTS; p++) begin
        ctrl_q[p] <= psc_pkg::CTRL_RESET;
      end
    end else begin
      for (int p = 0; p < NPORTS; p++) begin
        ctrl_q[p] <= ctrl_d[p];
      end
    end
  end

  // ---------------------------------------------------------------
  // Per-port merge
  // ---------------------------------------------------------------
  for (genvar g = 0; g < NPORTS; g++) begin : g_port
    psc_port_merge #(
      .PORT_IDX (2'(g))
    ) u_merge (
      .i_core_clk                   (i_core_clk),
      .i_rst                        (i_rst),
      .i_aneg_strap                 (s_aneg[g]),
      .i_duplex_strap               (s_dup[g]),
      .i_carrier_sense_select_strap (s_crs[g]),
      .i_serial_mode_strap          (s_ser[g]),
      .i_carrier_integrity_strap    (s_cim[g]),
      .i_codec_bypass_strap         (s_cod[g]),
      .i_scrambler_bypass_strap     (s_scr[g]),
      .i_speed_strap                (s_spd[g]),
      .i_fiber_mode_strap           (s_fib[g]),
      .i_broadcast_mgmt_strap       (s_bcast),
      .i_mgmt_address_upper_strap   (s_upper),
      .i_ctrl                       (ctrl_q[g]),
      .i_aneg_full_duplex           (i_aneg_full_duplex[g]),
      .i_aneg_speed_100             (i_aneg_speed_100[g]),
      .i_rx_active                  (i_rx_active[g]),
      .i_tx_active                  (i_tx_active[g]),
      .i_frame_addr                 (i_frame_addr),
      .i_frame_valid                (i_frame_valid),
      .o_aneg_enable                (o_aneg_enable[g]),
      .o_aneg_restart               (o_aneg_restart[g]),
      .o_full_duplex                (o_full_duplex[g]),
      .o_speed_100                  (o_speed_100[g]),
      .o_crs_rx_only                (o_crs_rx_only[g]),
      .o_serial_mode                (o_serial_mode[g]),
      .o_cim_enable                 (o_cim_enable[g]),
      .o_codec_bypass               (o_codec_bypass[g]),
      .o_scrambler_bypass           (o_scrambler_bypass[g]),
      .o_fiber_mode                 (o_fiber_mode[g]),
      .o_carrier_sense_out          (o_carrier_sense_out[g]),
      .o_mgmt_addr                  (o_mgmt_addr[5*g +: 5]),
      .o_addr_hit                   (o_addr_hit[g])
    );

    // Status word shows the merged state of the port
    always_comb begin
      stat_word[g]                         = 32'h0000_0000;
      stat_word[g][psc_pkg::BIT_FIBER]     = o_fiber_mode[g];
      stat_word[g][psc_pkg::BIT_SERIAL]    = o_serial_mode[g];
      stat_word[g][psc_pkg::BIT_CIM]       = o_cim_enable[g];
      stat_word[g][psc_pkg::BIT_SCR_BYP]   = o_scrambler_bypass[g];
      stat_word[g][psc_pkg::BIT_COD_BYP]   = o_codec_bypass[g];
      stat_word[g][psc_pkg::BIT_DUPLEX]    = o_full_duplex[g];
      stat_word[g][psc_pkg::BIT_CARRIER_SENSE_SELECT_STRAP]   = o_crs_rx_only[g];
      stat_word[g][psc_pkg::BIT_ANEG]      = o_aneg_enable[g];
      stat_word[g][psc_pkg::BIT_SPEED]     = o_speed_100[g];
      stat_word[g][psc_pkg::BIT_MADDR +: 5] = o_mgmt_addr[5*g +: 5];
      stat_word[g][psc_pkg::BIT_CRS_OUT]   = o_carrier_sense_out[g];
    end
  end

endmodule : psc_strap_config

`default_nettype wire

// File: psc_pkg.sv
package psc_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int unsigned NUM_PORTS = 4;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned CTRL_W    = 16;
  localparam int unsigned MADDR_W   = 5;
  localparam int unsigned UPPER_W   = 3;
  localparam int unsigned IDX_W     = 2;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STAT_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_GLOBAL    = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_STRIDE    = 8'h04;

  // ---------------------------------------------------------------
  // Field positions of the control and status words; BIT_BCAST and BIT_UPPER are in the global word
  // ---------------------------------------------------------------
  localparam int unsigned BIT_FIBER   = 0;
  localparam int unsigned BIT_SERIAL  = 1;
  localparam int unsigned BIT_CIM     = 3;
  localparam int unsigned BIT_SCR_BYP = 4;
  localparam int unsigned BIT_COD_BYP = 6;
  localparam int unsigned BIT_DUPLEX  = 8;
  localparam int unsigned BIT_CARRIER_SENSE_SELECT_STRAP = 10;
  localparam int unsigned BIT_ANEG    = 12;
  localparam int unsigned BIT_SPEED   = 13;
  localparam int unsigned BIT_MADDR   = 16;
  localparam int unsigned BIT_CRS_OUT = 24;
  localparam int unsigned BIT_BCAST   = 0;
  localparam int unsigned BIT_UPPER   = 4;

  // Writable bits of a control word
  localparam logic [CTRL_W-1:0] CTRL_WMASK = 16'h355B;

  // ---------------------------------------------------------------
  // Reset values and broadcast address
  // ---------------------------------------------------------------
  localparam logic [CTRL_W-1:0] CTRL_RESET  = 16'h3000;
  localparam logic [MADDR_W-1:0] BCAST_ADDR = 5'h00;

endpackage : psc_pkg

// File: psc_port_merge.sv
`timescale 1ns/1ps
`default_nettype none

module psc_port_merge #(
  parameter logic [1:0] PORT_IDX = 2'h0
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_aneg_strap,
  input  wire logic        i_duplex_strap,
  input  wire logic        i_carrier_sense_select_strap,
  input  wire logic        i_serial_mode_strap,
  input  wire logic        i_carrier_integrity_strap,
  input  wire logic        i_codec_bypass_strap,
  input  wire logic        i_scrambler_bypass_strap,
  input  wire logic        i_speed_strap,
  input  wire logic        i_fiber_mode_strap,
  input  wire logic        i_broadcast_mgmt_strap,
  input  wire logic [2:0]  i_mgmt_address_upper_strap,
  input  wire logic [15:0] i_ctrl,
  input  wire logic        i_aneg_full_duplex,
  input  wire logic        i_aneg_speed_100,
  input  wire logic        i_rx_active,
  input  wire logic        i_tx_active,
  input  wire logic [4:0]  i_frame_addr,
  input  wire logic        i_frame_valid,
  output logic             o_aneg_enable,
  output logic             o_aneg_restart,
  output logic             o_full_duplex,
  output logic             o_speed_100,
  output logic             o_crs_rx_only,
  output logic             o_serial_mode,
  output logic             o_cim_enable,
  output logic             o_codec_bypass,
  output logic             o_scrambler_bypass,
  output logic             o_fiber_mode,
  output logic             o_carrier_sense_out,
  output logic [4:0]       o_mgmt_addr,
  output logic             o_addr_hit
);

  // ---------------------------------------------------------------
  // Merge of straps and control bits
  // ---------------------------------------------------------------
  logic       strap_prev_q;
  logic       strap_prev_d;
  logic [15:0] out_q;
  logic [15:0] out_d;
  logic [4:0] addr_q;
  logic [4:0] addr_d;
  logic       aneg;
  logic       carrier_sense_select_strap;

  always_comb begin
    aneg         = i_aneg_strap & i_ctrl[psc_pkg::BIT_ANEG];
    carrier_sense_select_strap      = i_carrier_sense_select_strap | i_ctrl[psc_pkg::BIT_CARRIER_SENSE_SELECT_STRAP];
    strap_prev_d = i_aneg_strap;
    out_d        = '0;
    out_d[0]     = aneg;
    out_d[1]     = i_aneg_strap & ~strap_prev_q;
    if (aneg) begin
      out_d[2] = i_aneg_full_duplex & i_ctrl[psc_pkg::BIT_DUPLEX];
      out_d[3] = i_aneg_speed_100;
    end else begin
      out_d[2] = i_duplex_strap | i_ctrl[psc_pkg::BIT_DUPLEX];
      out_d[3] = i_speed_strap & i_ctrl[psc_pkg::BIT_SPEED];
    end
    out_d[4]  = carrier_sense_select_strap;
    out_d[5]  = i_serial_mode_strap | i_ctrl[psc_pkg::BIT_SERIAL];
    out_d[6]  = i_carrier_integrity_strap | i_ctrl[psc_pkg::BIT_CIM];
    out_d[7]  = i_codec_bypass_strap | i_ctrl[psc_pkg::BIT_COD_BYP];
    out_d[8]  = i_scrambler_bypass_strap | i_ctrl[psc_pkg::BIT_SCR_BYP];
    out_d[9]  = i_fiber_mode_strap | i_ctrl[psc_pkg::BIT_FIBER];
    out_d[10] = carrier_sense_select_strap ? i_rx_active : (i_rx_active | i_tx_active);
    addr_d    = {i_mgmt_address_upper_strap, PORT_IDX};
    out_d[11] = i_frame_valid & ((i_frame_addr == addr_q)
                | (i_broadcast_mgmt_strap & (i_frame_addr == psc_pkg::BCAST_ADDR)));
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      strap_prev_q <= 1'b0;
      out_q        <= 16'h0000;
      addr_q       <= 5'h00;
    end else begin
      strap_prev_q <= strap_prev_d;
      out_q        <= out_d;
      addr_q       <= addr_d;
    end
  end

  assign o_aneg_enable       = out_q[0];
  assign o_aneg_restart      = out_q[1];
  assign o_full_duplex       = out_q[2];
  assign o_speed_100         = out_q[3];
  assign o_crs_rx_only       = out_q[4];
  assign o_serial_mode       = out_q[5];
  assign o_cim_enable        = out_q[6];
  assign o_codec_bypass      = out_q[7];
  assign o_scrambler_bypass  = out_q[8];
  assign o_fiber_mode        = out_q[9];
  assign o_carrier_sense_out = out_q[10];
  assign o_addr_hit          = out_q[11];
  assign o_mgmt_addr         = addr_q;

endmodule : psc_port_merge

`default_nettype wire

// File: psc_strap_config_sva.sv
`timescale 1ns/1ps
`default_nettype none

module psc_strap_config_sva #(
  parameter int unsigned NPORTS = 4
) (
  input wire logic                i_core_clk,
  input wire logic                i_rst,
  input wire logic                i_psel,
  input wire logic                i_penable,
  input wire logic                o_pready,
  input wire logic [NPORTS-1:0]   i_aneg_strap,
  input wire logic [NPORTS-1:0]   i_aneg_full_duplex,
  input wire logic [NPORTS-1:0]   i_aneg_speed_100,
  input wire logic [NPORTS-1:0]   i_rx_active,
  input wire logic [NPORTS-1:0]   i_tx_active,
  input wire logic                i_broadcast_mgmt_strap,
  input wire logic [2:0]          i_mgmt_address_upper_strap,
  input wire logic [4:0]          i_frame_addr,
  input wire logic                i_frame_valid,
  input wire logic [NPORTS-1:0]   o_aneg_enable,
  input wire logic [NPORTS-1:0]   o_aneg_restart,
  input wire logic [NPORTS-1:0]   o_full_duplex,
  input wire logic [NPORTS-1:0]   o_speed_100,
  input wire logic [NPORTS-1:0]   o_crs_rx_only,
  input wire logic [NPORTS-1:0]   o_carrier_sense_out,
  input wire logic [5*NPORTS-1:0] o_mgmt_addr,
  input wire logic [NPORTS-1:0]   o_addr_hit
);
  // ----------
  // Edges since reset, saturating; pins need 3 to arrive
  // ----------
  logic [2:0] up_q;
  logic [2:0] up_d;
  always_comb begin
    up_d = (up_q == 3'h7) ? up_q : up_q + 3'h1;
  end
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      up_q <= 3'h0;
    end else begin
      up_q <= up_d;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  sequence s_setup; i_psel && !i_penable; endsequence
  sequence s_answer; o_pready ##1 !o_pready; endsequence
  sequence s_crs_steady; up_q >= 3'h2 ##0 $stable(o_crs_rx_only); endsequence
  sequence s_bc_frame;
    i_broadcast_mgmt_strap [*5] ##0 (i_frame_valid && i_frame_addr == 5'h00);
  endsequence

  property p_apb_answer; s_setup |=> s_answer; endproperty
  property p_aneg_and;
    up_q >= 3'h5 |-> (o_aneg_enable & ~$past(i_aneg_strap, 3)) == '0;
  endproperty
  property p_restart;
    up_q >= 3'h6 |-> o_aneg_restart == ($past(i_aneg_strap, 3) & ~$past(i_aneg_strap, 4));
  endproperty
  property p_dup_aneg;
    o_aneg_enable != '0 |-> (o_full_duplex & o_aneg_enable & ~$past(i_aneg_full_duplex)) == '0;
  endproperty
  property p_crs;
    s_crs_steady |-> o_carrier_sense_out == ((o_crs_rx_only & $past(i_rx_active))
      | (~o_crs_rx_only & $past(i_rx_active | i_tx_active)));
  endproperty
  property p_speed_aneg;
    o_aneg_enable != '0 |-> ((o_speed_100 ^ $past(i_aneg_speed_100)) & o_aneg_enable) == '0;
  endproperty
  property p_bcast; s_bc_frame |=> o_addr_hit == '1; endproperty
  property p_maddr;
    up_q >= 3'h5 |-> o_mgmt_addr == {$past(i_mgmt_address_upper_strap, 3), 2'h3,
      $past(i_mgmt_address_upper_strap, 3), 2'h2, $past(i_mgmt_address_upper_strap, 3), 2'h1,
      $past(i_mgmt_address_upper_strap, 3), 2'h0};
  endproperty

  a_apb_answer: assert property (p_apb_answer) else $error("pready not one cycle after setup");
  a_aneg_and: assert property (p_aneg_and) else $error("aneg on with strap low");
  a_restart: assert property (p_restart) else $error("restart pulse wrong");
  a_dup_aneg: assert property (p_dup_aneg) else $error("duplex strap used in aneg");
  a_crs: assert property (p_crs) else $error("carrier sense wrong");
  a_speed_aneg: assert property (p_speed_aneg) else $error("speed not aneg result");
  a_bcast: assert property (p_bcast) else $error("broadcast frame missed");
  a_maddr: assert property (p_maddr) else $error("management address wrong");
endmodule : psc_strap_config_sva

bind psc_strap_config psc_strap_config_sva #(.NPORTS(NPORTS)) psc_strap_config_sva_inst (.*);

`default_nettype wire

// File: psc_mgmt_station.sv
`timescale 1ns/1ps
`default_nettype none

module psc_mgmt_station (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic       i_send,
  input  wire logic [4:0] i_addr,
  output logic      [4:0] o_frame_addr,
  output logic            o_frame_valid
);
  // Address is junk outside a frame, so it keeps changing
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_frame_valid <= 1'b0;
      o_frame_addr  <= 5'h0A;
    end else begin
      o_frame_valid <= i_send;
      o_frame_addr  <= i_send ? i_addr : ~o_frame_addr;
    end
  end
endmodule : psc_mgmt_station

`default_nettype wire

// File: psc_strap_config_tb.sv
`timescale 1ns/1ps
`default_nettype none

module psc_strap_config_tb;
  logic        i_core_clk, i_rst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
  logic [7:0]  i_paddr;
  logic [31:0] i_pwdata, o_prdata;
  logic [3:0]  i_aneg_strap, i_duplex_strap, i_speed_strap, i_aneg_full_duplex;
  logic [3:0]  i_aneg_speed_100, i_rx_active, i_tx_active, o_addr_hit;
  logic [3:0]  o_aneg_enable, o_aneg_restart, o_full_duplex, o_speed_100, o_carrier_sense_out;
  logic        i_broadcast_mgmt_strap, i_frame_valid, send;
  logic [2:0]  i_mgmt_address_upper_strap;
  logic [4:0]  i_frame_addr, send_addr;
  logic [19:0] o_mgmt_addr;
  logic [3:0]  st [6];
  wire  [3:0]  ov [6];
  int          ob [6] = '{psc_pkg::BIT_FIBER, psc_pkg::BIT_SERIAL, psc_pkg::BIT_CIM,
                          psc_pkg::BIT_SCR_BYP, psc_pkg::BIT_COD_BYP, psc_pkg::BIT_CARRIER_SENSE_SELECT_STRAP};
  int          errors, n_checks;

  psc_strap_config psc_strap_config_inst (.*,
    .i_fiber_mode_strap(st[0]), .i_serial_mode_strap(st[1]), .i_carrier_integrity_strap(st[2]),
    .i_scrambler_bypass_strap(st[3]), .i_codec_bypass_strap(st[4]),
    .i_carrier_sense_select_strap(st[5]), .o_fiber_mode(ov[0]), .o_serial_mode(ov[1]),
    .o_cim_enable(ov[2]), .o_scrambler_bypass(ov[3]), .o_codec_bypass(ov[4]),
    .o_crs_rx_only(ov[5]));
  psc_mgmt_station psc_mgmt_station_inst (.i_core_clk, .i_rst, .i_send(send),
    .i_addr(send_addr), .o_frame_addr(i_frame_addr), .o_frame_valid(i_frame_valid));

  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  // ----------
  // Shared tasks
  // ----------
  task automatic step(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask : step

  task automatic close_out;
    $display("checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int k;
    step(1);
    i_psel <= 1'b1; i_penable <= 1'b0; i_pwrite <= w; i_paddr <= a; i_pwdata <= wd;
    step(1);
    i_penable <= 1'b1;
    k = 1;
    step(1);
    while (o_pready !== 1'b1 && k < 20) begin
      step(1); k++;
    end
    if (o_pready !== 1'b1) begin
      errors++;
      close_out();
    end
    rd = o_prdata; er = o_pslverr;
    i_psel <= 1'b0; i_penable <= 1'b0;
  endtask : apb

  task automatic frame(input logic [4:0] a, input logic [3:0] e);
    step(1); send <= 1'b1; send_addr <= a;
    step(1); send <= 1'b0;
    step(1); #1; chk("addr hit", 32'(e), 32'(o_addr_hit));
  endtask : frame

  // ----------
  // Scenarios
  // ----------
  task automatic t_reset;
    logic [31:0] rd; logic er;
    apb(1'b0, 8'h0C, 32'h0, rd, er);
    chk("ctrl3 reset", 32'(psc_pkg::CTRL_RESET), rd);
    chk("aneg off", 32'h0, o_aneg_enable);
  endtask : t_reset

  task automatic t_or;
    logic [31:0] rd; logic er; int f, n;
    for (f = 0; f < 6; f++) for (n = 0; n < 4; n++) begin
      step(1); st[f] <= 4'h1 << n;
      step(4); #1; chk("strap or", 32'h1 << n, ov[f]);
      step(1); st[f] <= 4'h0;
      apb(1'b1, 8'(4 * n), 32'(psc_pkg::CTRL_RESET) | (32'h1 << ob[f]), rd, er);
      step(1); #1; chk("ctrl or", 32'h1 << n, ov[f]);
      apb(1'b1, 8'(4 * n), 32'(psc_pkg::CTRL_RESET), rd, er);
    end
  endtask : t_or

  task automatic t_aneg;
    logic [31:0] rd; logic er;
    step(1); i_aneg_strap <= 4'h4; i_aneg_speed_100 <= 4'hA; i_aneg_full_duplex <= 4'h0;
    i_duplex_strap <= 4'hF; i_speed_strap <= 4'hF;
    step(3); #1; chk("restart", 32'h4, o_aneg_restart);
    step(1); #1; chk("restart end", 32'h0, o_aneg_restart);
    chk("aneg on", 32'h4, o_aneg_enable);
    chk("speed", 32'hB, o_speed_100);
    chk("duplex", 32'hB, o_full_duplex);
    apb(1'b1, 8'h08, 32'h2000, rd, er);
    apb(1'b1, 8'h00, 32'h0000, rd, er);
    apb(1'b1, 8'h04, 32'h3100, rd, er);
    step(1); i_speed_strap <= 4'h7; i_duplex_strap <= 4'h0;
    step(4); #1; chk("aneg bit off", 32'h0, o_aneg_enable);
    chk("speed and", 32'h6, o_speed_100);
    chk("duplex bit", 32'h2, o_full_duplex);
    for (int n = 0; n < 3; n++) apb(1'b1, 8'(4 * n), 32'(psc_pkg::CTRL_RESET), rd, er);
    step(1); i_aneg_strap <= 4'h0;
    step(4);
  endtask : t_aneg

  task automatic t_addr;
    int u, n;
    logic [31:0] rd; logic er;
    for (u = 0; u < 8; u++) begin
      step(1); i_mgmt_address_upper_strap <= 3'(u);
      step(4); #1;
      for (n = 0; n < 4; n++) chk("mgmt addr", {u[2:0], n[1:0]}, o_mgmt_addr[5*n +: 5]);
      frame({u[2:0], u[1:0]}, 4'h1 << u[1:0]);
    end
    frame(5'h00, 4'h0);
    step(1); i_broadcast_mgmt_strap <= 1'b1;
    step(5); frame(5'h00, 4'hF);
    frame(5'h1D, 4'h2);
    apb(1'b0, 8'h20, 32'h0, rd, er);
    chk("global word", 32'h0000_0071, rd);
    apb(1'b0, 8'h14, 32'h0, rd, er);
    chk("status port1", 32'h001D_2000, rd);
    chk("status slverr", 32'h0, er);
    step(1); i_broadcast_mgmt_strap <= 1'b0;
  endtask : t_addr

  task automatic t_crs;
    step(1); st[5] <= 4'h2; i_tx_active <= 4'hF; i_rx_active <= 4'h0;
    step(4); #1; chk("carrier sense", 32'hD, o_carrier_sense_out);
    step(1); i_tx_active <= 4'h0; i_rx_active <= 4'h2;
    step(1); #1; chk("carrier sense rx", 32'h2, o_carrier_sense_out);
    step(1); st[5] <= 4'h0; i_rx_active <= 4'h0;
  endtask : t_crs

  task automatic t_err;
    logic [31:0] rd; logic er;
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, i ? 8'h24 : 8'h02, 32'hFFFF_FFFF, rd, er);
      chk("write slverr", 32'h1, er);
      apb(1'b0, i ? 8'h24 : 8'h02, 32'h0, rd, er);
      chk("read slverr", 32'h1, er);
      chk("read data", 32'h0, rd);
    end
    apb(1'b0, 8'h00, 32'h0, rd, er);
    chk("ctrl0 kept", 32'(psc_pkg::CTRL_RESET), rd);
  endtask : t_err

  initial begin
    i_rst = 1'b1; i_psel = 1'b0; i_penable = 1'b0; i_pwrite = 1'b0;
    i_paddr = 8'h00; i_pwdata = 32'h0; send = 1'b0; send_addr = 5'h00;
    i_aneg_strap = 4'h0; i_duplex_strap = 4'h0; i_speed_strap = 4'h0;
    i_aneg_full_duplex = 4'h0; i_aneg_speed_100 = 4'h0; i_rx_active = 4'h0;
    i_tx_active = 4'h0; i_broadcast_mgmt_strap = 1'b0; i_mgmt_address_upper_strap = 3'h0;
    st = '{default: 4'h0};
    errors = 0; n_checks = 0;
    step(3);
    i_rst <= 1'b0;
    step(5);
    t_reset();
    t_or();
    t_aneg();
    t_addr();
    t_crs();
    t_err();
    close_out();
  end
endmodule : psc_strap_config_tb

`default_nettype wire
